//--- design/twdp_params.svh
//==============================================================================
// Purpose: Constants of the two-wire digital potentiometer slave
// Assumes: 200 MHz system clock
// Notes:   Included by the design, checker and bench files
//==============================================================================
`ifndef TWDP_PARAMS_SVH
`define TWDP_PARAMS_SVH

// Device type code in the top nibble of the address byte (value is arbitrary)
`define TWDP_DEVICE_ID 4'hA

// Field positions of the address byte
`define TWDP_ID_HI 7
`define TWDP_ID_LO 4
`define TWDP_ADDR_HI 3
`define TWDP_ADDR_LO 1
`define TWDP_RW_BIT 0

// Field positions of the instruction byte
`define TWDP_OP_HI 7
`define TWDP_OP_LO 5
`define TWDP_SEL_HI 3
`define TWDP_SEL_LO 2

// Instruction opcodes
`define TWDP_OP_RD_WIPER 3'h4
`define TWDP_OP_WR_WIPER 3'h5
`define TWDP_OP_RD_DR 3'h3
`define TWDP_OP_WR_DR 3'h6
`define TWDP_OP_DR_TO_WIPER 3'h7
`define TWDP_OP_WIPER_TO_DR 3'h2

// Widths, register count and reset contents
`define TWDP_WIPER_W 10
`define TWDP_TAPS 1024
`define TWDP_NUM_DR 4
`define TWDP_DEFAULT_DR 2'h0
`define TWDP_RESET_POSITION 10'h200
`define TWDP_BIT_LAST 3'h7

// Nonvolatile write cycle time
`define TWDP_CLK_NS 5
`define TWDP_NV_WRITE_NS 5000000
`define TWDP_NV_WRITE_CYCLES (`TWDP_NV_WRITE_NS / `TWDP_CLK_NS)
`define TWDP_TIMER_W 20

`endif

//--- design/twdp_pkg.sv
//==============================================================================
// Purpose: Types of the two-wire digital potentiometer slave
// Assumes: Nothing
// Notes:   One-hot protocol states
//==============================================================================
package twdp_pkg;

   typedef enum logic [8:0] {
      TWDP_IDLE      = 9'h001,
      TWDP_ADDR      = 9'h002,
      TWDP_ADDR_ACK  = 9'h004,
      TWDP_INSTR     = 9'h008,
      TWDP_INSTR_ACK = 9'h010,
      TWDP_WDATA     = 9'h020,
      TWDP_WDATA_ACK = 9'h040,
      TWDP_RDATA     = 9'h080,
      TWDP_RDATA_ACK = 9'h100
   } twdp_state_t;

endpackage : twdp_pkg

//--- design/twdp_slave.sv
//==============================================================================
// Purpose: Two-wire bus slave of a single digital potentiometer
// Assumes: Serial clock from the master, far slower than clk_sys
// Notes:   Bits are caught on the serial clock, decoded on clk_sys
//==============================================================================
// Overview of operation
// RULE1: Data bits are sampled on each rising edge of the serial clock.
// RULE2: Returned data changes on the serial data line only after falling edges.
// RULE3: The data line is only pulled low or released, never driven high.
// RULE4: The master supplies the serial clock; this block only receives it.
// RULE5: The low three slave address bits come from the address strap pins.
// RULE6: A transaction starts only when received address bits match the straps.
// RULE7: While protect is low, no nonvolatile data register write happens.
// RULE8: After reset the wiper register is loaded from the default data register.
// RULE9: The volatile wiper register directly selects the connected tap switch.
// RULE10: The wiper register is 10 bits and selects one of 1024 taps.
// RULE11: Four nonvolatile data registers are writable and readable over the bus.
// RULE12: Write, read and transfer operations between data and wiper registers.
// RULE13: Address byte: type code, three address bits, then read/write bit.
// RULE14: The instruction byte carries a three-bit opcode in its top bits.
// RULE15: Two select bits of the instruction byte pick one data register.
// RULE16: During a nonvolatile write cycle the slave address is not acknowledged.
// RULE17: After an address mismatch the line is released until the next start.
// RULE18: A protected write leaves data unchanged and starts no write cycle.
`timescale 1ns/10ps
`include "twdp_params.svh"

module twdp_slave #(
   parameter int unsigned NV_WRITE_CYCLES = `TWDP_NV_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [2:0] addr_strap_pins,
   input wire logic write_protect_n,
   output logic [`TWDP_WIPER_W-1:0] wiper_position_reg,
   output logic [`TWDP_TAPS-1:0] tap_enable,
   output logic nv_busy
);

   //===========================================================================
   // Declarations
   //===========================================================================
   logic link_bit;
   logic link_tgl;
   logic tgl_m, tgl_s, tgl_d;
   logic scl_m, scl_s;
   logic sda_m, sda_s, sda_d;
   logic [2:0] strap_m, strap_s;
   logic wp_m, wp_s;
   logic start_evt, stop_evt, bit_evt;
   twdp_pkg::twdp_state_t state;
   logic [2:0] bit_cnt;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [7:0] tx;
   logic [7:0] data_lo;
   logic rw;
   logic byte_idx;
   logic [2:0] instr_opcode;
   logic reg_select_hi, reg_select_lo;
   logic [1:0] sel;
   logic drive_req;
   logic pend_nv;
   logic pend_xfer;
   logic [`TWDP_WIPER_W-1:0] pend_value;
   logic wiper_load;
   logic [`TWDP_WIPER_W-1:0] wiper_value;
   logic nv_write;
   logic [1:0] nv_sel;
   logic [`TWDP_WIPER_W-1:0] nv_value;
   logic [`TWDP_WIPER_W-1:0] stored_position [`TWDP_NUM_DR];
   logic [`TWDP_WIPER_W-1:0] default_stored_position;
   logic [`TWDP_WIPER_W-1:0] rd_value;
   logic [7:0] rd_lo, rd_hi;
   logic recall_pending;
   logic [`TWDP_TIMER_W-1:0] busy_cnt;
   logic addr_match;

   //===========================================================================
   // Serial clock domain
   //===========================================================================
   // Each rising edge catches the line and flips a toggle; the bit stays put
   // until the next rising edge, long after clk_sys has taken it
   always_ff @(posedge scl or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_bit <= 1'b0;
         link_tgl <= 1'b0;
      end
      else
      begin
         link_bit <= sda_in; // see RULE1
         link_tgl <= ~link_tgl;
      end
   end

   // Drive request is settled a few clk_sys cycles after the rising edge,
   // so it is stable when the falling edge takes it
   always_ff @(negedge scl or posedge sys_rst)
   begin
      if (sys_rst)
         sda_oe <= 1'b0;
      else
         sda_oe <= drive_req; // see RULE2
   end

   // Only ever pulls the line low
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0; // see RULE3
   end

   //===========================================================================
   // Synchronisers
   //===========================================================================
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tgl_m <= 1'b0;
         tgl_s <= 1'b0;
         tgl_d <= 1'b0;
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         strap_m <= 3'h0;
         strap_s <= 3'h0;
         wp_m <= 1'b0;
         wp_s <= 1'b0;
      end
      else
      begin
         tgl_m <= link_tgl;
         tgl_s <= tgl_m;
         tgl_d <= tgl_s;
         scl_m <= scl;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         strap_m <= addr_strap_pins;
         strap_s <= strap_m;
         wp_m <= write_protect_n;
         wp_s <= wp_m;
      end
   end

   assign start_evt = scl_s & sda_d & ~sda_s;
   assign stop_evt = scl_s & ~sda_d & sda_s;
   assign bit_evt = tgl_s ^ tgl_d;
   assign next_shift = {shift[6:0], link_bit};

   //===========================================================================
   // Decode of received bytes
   //===========================================================================
   assign addr_match = (next_shift[`TWDP_ID_HI:`TWDP_ID_LO] == `TWDP_DEVICE_ID) // see RULE13
      && (next_shift[`TWDP_ADDR_HI:`TWDP_ADDR_LO] == strap_s); // see RULE5
   assign reg_select_hi = next_shift[`TWDP_SEL_HI];
   assign reg_select_lo = next_shift[`TWDP_SEL_LO];
   assign default_stored_position = stored_position[`TWDP_DEFAULT_DR];
   assign rd_value = (instr_opcode == `TWDP_OP_RD_WIPER) ? wiper_position_reg
      : stored_position[sel]; // see RULE11
   assign rd_lo = rd_value[7:0];
   assign rd_hi = {6'h00, rd_value[`TWDP_WIPER_W-1:8]};

   //===========================================================================
   // Protocol engine
   //===========================================================================
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= twdp_pkg::TWDP_IDLE;
         bit_cnt <= 3'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         data_lo <= 8'h00;
         rw <= 1'b0;
         byte_idx <= 1'b0;
         instr_opcode <= 3'h0;
         sel <= 2'h0;
         drive_req <= 1'b0;
         pend_nv <= 1'b0;
         pend_xfer <= 1'b0;
         pend_value <= `TWDP_RESET_POSITION;
         wiper_load <= 1'b0;
         wiper_value <= `TWDP_RESET_POSITION;
         nv_write <= 1'b0;
         nv_sel <= 2'h0;
         nv_value <= `TWDP_RESET_POSITION;
      end
      else
      begin
         wiper_load <= 1'b0;
         nv_write <= 1'b0;
         if (start_evt)
         begin
            state <= twdp_pkg::TWDP_ADDR;
            bit_cnt <= 3'h0;
            drive_req <= 1'b0;
            pend_nv <= 1'b0;
            pend_xfer <= 1'b0;
         end
         else if (stop_evt)
         begin
            state <= twdp_pkg::TWDP_IDLE;
            drive_req <= 1'b0;
            pend_nv <= 1'b0;
            pend_xfer <= 1'b0;
            // Internal write cycle starts at the stop, unless protected
            if (pend_nv && wp_s) // see RULE7, RULE18
            begin
               nv_write <= 1'b1;
               nv_sel <= sel;
               nv_value <= pend_value;
            end
            if (pend_xfer)
            begin
               wiper_load <= 1'b1; // see RULE12
               wiper_value <= stored_position[sel];
            end
         end
         else if (bit_evt)
         begin
            case (state)
               twdp_pkg::TWDP_ADDR:
               begin
                  shift <= next_shift;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == `TWDP_BIT_LAST)
                  begin
                     if (addr_match && !nv_busy) // see RULE6, RULE16
                     begin
                        rw <= next_shift[`TWDP_RW_BIT];
                        drive_req <= 1'b1;
                        state <= twdp_pkg::TWDP_ADDR_ACK;
                     end
                     else
                        state <= twdp_pkg::TWDP_IDLE; // see RULE17
                  end
               end
               twdp_pkg::TWDP_ADDR_ACK:
               begin
                  drive_req <= 1'b0;
                  bit_cnt <= 3'h0;
                  state <= twdp_pkg::TWDP_INSTR;
               end
               twdp_pkg::TWDP_INSTR:
               begin
                  shift <= next_shift;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == `TWDP_BIT_LAST)
                  begin
                     instr_opcode <= next_shift[`TWDP_OP_HI:`TWDP_OP_LO]; // see RULE14
                     sel <= {reg_select_hi, reg_select_lo}; // see RULE15
                     if (next_shift[`TWDP_OP_HI:`TWDP_OP_LO] == `TWDP_OP_WIPER_TO_DR)
                     begin
                        pend_nv <= 1'b1; // see RULE12
                        pend_value <= wiper_position_reg;
                     end
                     if (next_shift[`TWDP_OP_HI:`TWDP_OP_LO] == `TWDP_OP_DR_TO_WIPER)
                        pend_xfer <= 1'b1;
                     drive_req <= 1'b1;
                     state <= twdp_pkg::TWDP_INSTR_ACK;
                  end
               end
               twdp_pkg::TWDP_INSTR_ACK:
               begin
                  bit_cnt <= 3'h0;
                  byte_idx <= 1'b0;
                  if (rw)
                  begin
                     tx <= rd_lo;
                     drive_req <= ~rd_lo[7];
                     state <= twdp_pkg::TWDP_RDATA;
                  end
                  else
                  begin
                     drive_req <= 1'b0;
                     state <= twdp_pkg::TWDP_WDATA;
                  end
               end
               twdp_pkg::TWDP_WDATA:
               begin
                  shift <= next_shift;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == `TWDP_BIT_LAST)
                  begin
                     drive_req <= 1'b1;
                     state <= twdp_pkg::TWDP_WDATA_ACK;
                     if (!byte_idx)
                        data_lo <= next_shift;
                     else if (instr_opcode == `TWDP_OP_WR_WIPER)
                     begin
                        wiper_load <= 1'b1; // see RULE12
                        wiper_value <= {next_shift[1:0], data_lo};
                     end
                     else if (instr_opcode == `TWDP_OP_WR_DR)
                     begin
                        pend_nv <= 1'b1; // see RULE11
                        pend_value <= {next_shift[1:0], data_lo};
                     end
                  end
               end
               twdp_pkg::TWDP_WDATA_ACK:
               begin
                  drive_req <= 1'b0;
                  bit_cnt <= 3'h0;
                  byte_idx <= 1'b1;
                  state <= twdp_pkg::TWDP_WDATA;
               end
               twdp_pkg::TWDP_RDATA:
               begin
                  bit_cnt <= bit_cnt + 3'h1;
                  tx <= {tx[6:0], 1'b0};
                  if (bit_cnt == `TWDP_BIT_LAST)
                  begin
                     drive_req <= 1'b0;
                     state <= twdp_pkg::TWDP_RDATA_ACK;
                  end
                  else
                     drive_req <= ~tx[6]; // see RULE3
               end
               twdp_pkg::TWDP_RDATA_ACK:
               begin
                  bit_cnt <= 3'h0;
                  if (!link_bit && !byte_idx)
                  begin
                     byte_idx <= 1'b1;
                     tx <= rd_hi;
                     drive_req <= ~rd_hi[7];
                     state <= twdp_pkg::TWDP_RDATA;
                  end
                  else
                     state <= twdp_pkg::TWDP_IDLE;
               end
               default:
                  state <= twdp_pkg::TWDP_IDLE;
            endcase
         end
      end
   end

   //===========================================================================
   // Nonvolatile data registers and write cycle timer
   //===========================================================================
   genvar g;
   generate
      for (g = 0; g < `TWDP_NUM_DR; g = g + 1)
      begin : g_dr
         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
               stored_position[g] <= `TWDP_RESET_POSITION;
            else if (nv_write && (nv_sel == 2'(g)))
               stored_position[g] <= nv_value; // see RULE11
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_cnt <= '0;
         nv_busy <= 1'b0;
      end
      else if (nv_write)
      begin
         busy_cnt <= `TWDP_TIMER_W'(NV_WRITE_CYCLES);
         nv_busy <= 1'b1; // see RULE16
      end
      else if (busy_cnt != '0)
      begin
         busy_cnt <= busy_cnt - `TWDP_TIMER_W'(1);
         nv_busy <= (busy_cnt != `TWDP_TIMER_W'(1));
      end
   end

   //===========================================================================
   // Wiper register and tap decode
   //===========================================================================
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         recall_pending <= 1'b1;
      else
         recall_pending <= 1'b0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         wiper_position_reg <= `TWDP_RESET_POSITION;
      else if (recall_pending)
         wiper_position_reg <= default_stored_position; // see RULE8
      else if (wiper_load)
         wiper_position_reg <= wiper_value; // see RULE9
   end

   generate
      for (g = 0; g < `TWDP_TAPS; g = g + 1)
      begin : g_tap
         always_ff @(posedge clk_sys or posedge sys_rst)
         begin
            if (sys_rst)
               tap_enable[g] <= 1'b0;
            else
               tap_enable[g] <= (wiper_position_reg == `TWDP_WIPER_W'(g)); // see RULE10
         end
      end
   endgenerate

endmodule : twdp_slave

//--- sim/twdp_master.sv
// Purpose: Two-wire bus master model that drives the serial clock
// Assumes: Open-drain data line with a pull-up, resolved by the bench
// Notes:   Each serial clock phase lasts eight periods of a 15 ns link clock
`timescale 1ns/10ps

module twdp_master (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   logic lnk_clk = 1'b0;

   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
      #1.3;
      forever #7.5 lnk_clk = ~lnk_clk;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge lnk_clk);
   endtask : wt

   // Data moves only in the low phase and is sampled mid high phase
   task automatic bit_slot(input logic b, output logic r);
      wt(2);
      sda_pull = ~b;
      wt(6);
      scl = 1'b1;
      wt(4);
      r = sda;
      wt(4);
      scl = 1'b0;
   endtask : bit_slot

   task automatic start_cond();
      wt(4);
      sda_pull = 1'b1;
      wt(8);
      scl = 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      wt(2);
      sda_pull = 1'b1;
      wt(6);
      scl = 1'b1;
      wt(8);
      sda_pull = 1'b0;
      wt(8);
   endtask : stop_cond

   // Most significant bit first, then a released slot for the acknowledge
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_slot(d[i], r);
      bit_slot(1'b1, r);
      ack = ~r;
   endtask : send_byte

   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_slot(1'b1, d[i]);
      bit_slot(last, r);
   endtask : recv_byte
endmodule : twdp_master

//--- sim/twdp_slave_checker.sv
// Purpose: Port-level assertions for the potentiometer slave
// Assumes: Bound to every twdp_slave instance
// Notes:   All properties sampled on clk_sys
`timescale 1ns/10ps
`include "twdp_params.svh"

module twdp_slave_checker #(
   parameter int unsigned NV_WRITE_CYCLES = `TWDP_NV_WRITE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [2:0] addr_strap_pins,
   input wire logic write_protect_n,
   input wire logic [`TWDP_WIPER_W-1:0] wiper_position_reg,
   input wire logic [`TWDP_TAPS-1:0] tap_enable,
   input wire logic nv_busy
);
   localparam logic [`TWDP_TAPS-1:0] TAP_ONE = 1;
   int unsigned busy_cnt;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         busy_cnt <= 0;
      else
         busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
   end

   default clocking dck @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data output driven high");
   oe_falling_a: assert property ($changed(sda_oe) |-> $fell(scl))
      else $error("data line changed away from a falling clock");
   tap_select_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> tap_enable == (TAP_ONE << $past(wiper_position_reg)))
      else $error("tap select does not follow wiper");
   wiper_move_a: assert property ($changed(wiper_position_reg) |-> scl && !nv_busy)
      else $error("wiper moved outside a bus command");
   busy_length_a: assert property ($fell(nv_busy) |-> busy_cnt == NV_WRITE_CYCLES)
      else $error("store cycle length wrong");
   busy_after_stop_a: assert property ($rose(nv_busy) |-> scl && sda_in && $past(scl, 2))
      else $error("store cycle started outside a stop");
   busy_no_ack_a: assert property ($rose(sda_oe) |-> !nv_busy)
      else $error("acknowledge during store cycle");
   protect_store_a: assert property ($rose(nv_busy)
      |-> write_protect_n && $past(write_protect_n, 8))
      else $error("store cycle while protected");
endmodule : twdp_slave_checker

bind twdp_slave twdp_slave_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) twdp_slave_checker_i (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .addr_strap_pins(addr_strap_pins), .write_protect_n(write_protect_n),
   .wiper_position_reg(wiper_position_reg), .tap_enable(tap_enable), .nv_busy(nv_busy));

//--- sim/test_two_wire_digital_pot_slave.sv
// Purpose: Self-checking bench of the potentiometer slave
// Assumes: Seed 82, store cycle shortened to 1000 clocks
// Notes:   The bus master model drives the serial clock
`timescale 1ns/10ps
`include "twdp_params.svh"

module test_two_wire_digital_pot_slave;
   localparam int unsigned NV_CYC = 1000;
   localparam int LIMIT = 90000;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b0;
   logic write_protect_n = 1'b1;
   logic [2:0] addr_strap_pins = 3'h0;
   logic scl, sda_pull, sda_line, sda_out, sda_oe, nv_busy, ok;
   logic [`TWDP_WIPER_W-1:0] wiper_position_reg;
   logic [`TWDP_TAPS-1:0] tap_enable;
   logic [6:0] tgt;
   logic [9:0] dr_m [4];
   logic [9:0] wiper_m, rv, v;
   int n;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #2.5 clk_sys = ~clk_sys;
   // Pull-up: the line is low only while some party pulls it
   assign sda_line = (sda_pull | sda_oe) ? 1'b0 : 1'b1;

   twdp_slave #(.NV_WRITE_CYCLES(NV_CYC)) twdp_slave_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_pins(addr_strap_pins), .write_protect_n(write_protect_n),
      .wiper_position_reg(wiper_position_reg), .tap_enable(tap_enable), .nv_busy(nv_busy));
   twdp_master twdp_master_i (.scl(scl), .sda_pull(sda_pull), .sda(sda_line));

   function automatic logic [`TWDP_TAPS-1:0] tap_of(input logic [9:0] w);
      return {{(`TWDP_TAPS-1){1'b0}}, 1'b1} << w;
   endfunction : tap_of

   task automatic check(input string what, input logic [`TWDP_TAPS-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   // One full command: address, instruction, data bytes as the opcode needs
   task automatic cmd(input logic [2:0] op, input logic [1:0] sel, input logic [9:0] wv,
      output logic [9:0] r, output logic a);
      logic rd, k, ea;
      logic [7:0] lo, hi;
      rd = (op == `TWDP_OP_RD_WIPER) || (op == `TWDP_OP_RD_DR);
      r = 10'h000;
      // Only the own address is answered; callers never send while a store runs
      ea = (tgt == {`TWDP_DEVICE_ID, addr_strap_pins});
      twdp_master_i.start_cond();
      twdp_master_i.send_byte({tgt, rd}, a);
      check("address ack", a, ea);
      twdp_master_i.send_byte({op, 1'b0, sel, 2'b00}, k);
      check("instruction ack", k, ea);
      if (rd)
      begin
         twdp_master_i.recv_byte(1'b0, lo);
         twdp_master_i.recv_byte(1'b1, hi);
         r = {hi[1:0], lo};
         check("read high bits", hi[7:2], 6'h00);
      end
      else if (op == `TWDP_OP_WR_WIPER || op == `TWDP_OP_WR_DR)
      begin
         twdp_master_i.send_byte(wv[7:0], k);
         check("data ack", k, ea);
         twdp_master_i.send_byte({6'h00, wv[9:8]}, k);
         check("data ack", k, ea);
      end
      twdp_master_i.stop_cond();
   endtask : cmd

   // Address-only probes until acknowledged or eight probes sent
   task automatic poll(output int cnt);
      logic a;
      cnt = 0;
      a = 1'b0;
      while (!a && cnt < 8)
      begin
         twdp_master_i.start_cond();
         twdp_master_i.send_byte({tgt, 1'b0}, a);
         twdp_master_i.stop_cond();
         cnt++;
      end
   endtask : poll

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         fails++;
         wrap_up();
      end
   end

   initial
   begin
      void'($urandom(82));
      // Raised after time zero so the serial clock domain sees a reset edge
      #1;
      sys_rst = 1'b1;
      for (int i = 0; i < 4; i++)
         dr_m[i] = `TWDP_RESET_POSITION;
      wiper_m = `TWDP_RESET_POSITION;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("wiper after reset", wiper_position_reg, dr_m[`TWDP_DEFAULT_DR]);
      check("taps after reset", tap_enable, tap_of(wiper_m));
      for (int i = 0; i < 5; i++)
      begin
         @(negedge clk_sys);
         addr_strap_pins = 3'($urandom);
         tgt = {`TWDP_DEVICE_ID, addr_strap_pins};
         v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
         cmd(`TWDP_OP_WR_WIPER, 2'h0, v, rv, ok);
         wiper_m = v;
         check("address ack", ok, 1'b1);
         check("wiper", wiper_position_reg, wiper_m);
         check("taps", tap_enable, tap_of(wiper_m));
         cmd(`TWDP_OP_RD_WIPER, 2'h0, 10'h000, rv, ok);
         check("wiper read", rv, wiper_m);
      end
      for (int i = 0; i < 2; i++)
      begin
         tgt = (i == 0) ? {`TWDP_DEVICE_ID, addr_strap_pins ^ 3'h4} :
            {~`TWDP_DEVICE_ID, addr_strap_pins};
         cmd(`TWDP_OP_WR_WIPER, 2'h0, ~wiper_m, rv, ok);
         check("foreign address ack", ok, 1'b0);
         check("wiper kept", wiper_position_reg, wiper_m);
      end
      tgt = {`TWDP_DEVICE_ID, addr_strap_pins};
      for (int s = 0; s < 4; s++)
      begin
         v = 10'($urandom);
         cmd(`TWDP_OP_WR_DR, 2'(s), v, rv, ok);
         dr_m[s] = v;
         check("busy after store", nv_busy, 1'b1);
         poll(n);
         check("polls until ready", (n > 1 && n < 8), 1'b1);
         cmd(`TWDP_OP_RD_DR, 2'(s), 10'h000, rv, ok);
         check("data register read", rv, dr_m[s]);
      end
      for (int s = 0; s < 4; s++)
      begin
         cmd(`TWDP_OP_DR_TO_WIPER, 2'(s), 10'h000, rv, ok);
         wiper_m = dr_m[s];
         check("recalled wiper", wiper_position_reg, wiper_m);
         check("recalled taps", tap_enable, tap_of(wiper_m));
      end
      cmd(`TWDP_OP_WIPER_TO_DR, 2'h1, 10'h000, rv, ok);
      dr_m[1] = wiper_m;
      poll(n);
      cmd(`TWDP_OP_RD_DR, 2'h1, 10'h000, rv, ok);
      check("saved wiper", rv, dr_m[1]);
      @(negedge clk_sys);
      write_protect_n = 1'b0;
      cmd(`TWDP_OP_WR_DR, 2'h2, ~dr_m[2], rv, ok);
      check("busy while protected", nv_busy, 1'b0);
      cmd(`TWDP_OP_WIPER_TO_DR, 2'h2, 10'h000, rv, ok);
      check("busy while protected", nv_busy, 1'b0);
      cmd(`TWDP_OP_RD_DR, 2'h2, 10'h000, rv, ok);
      check("protected register", rv, dr_m[2]);
      @(negedge clk_sys);
      write_protect_n = 1'b1;
      sys_rst = 1'b1;
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("wiper after reset", wiper_position_reg, `TWDP_RESET_POSITION);
      check("taps after reset", tap_enable, tap_of(`TWDP_RESET_POSITION));
      wrap_up();
   end
endmodule : test_two_wire_digital_pot_slave
